// *** cpm_params.svh ***
// named constants of the channel protection monitor
// assumes voltage in mV, power in 10 mW, temperature in degC, delays in ms
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CPM_VW            16
`define CPM_PW            16
`define CPM_TW            8
`define CPM_DW            16
`define CPM_CW            16

// ****************************************************************
// module ratings and reset values
// ****************************************************************
`define CPM_V_MAX         16'h9c40
`define CPM_V_MARGIN      16'h01f4
`define CPM_V_TRIP_MAX    (`CPM_V_MAX + `CPM_V_MARGIN)
`define CPM_P_MAX         16'h3c8c
`define CPM_T_TRIP_RST    8'h3c
`define CPM_HW_SHIFT      5
`define CPM_HAS_HW_CMP    1'b1

// ****************************************************************
// timing
// ****************************************************************
`define CPM_CLK_PERIOD_NS 100
`define CPM_MS_NS         1000000

`endif

// *** cpm_pkg.sv ***
// types shared by the channel protection monitor files
// assumes cpm_params.svh is on the include path
`include "cpm_params.svh"

package cpm_pkg;

    typedef logic [`CPM_VW-1:0] cpm_volt_t;
    typedef logic [`CPM_PW-1:0] cpm_pow_t;
    typedef logic [`CPM_TW-1:0] cpm_temp_t;
    typedef logic [`CPM_DW-1:0] cpm_ms_t;

    typedef enum logic {CPM_VG_SW, CPM_VG_HW} cpm_vg_type_e;

    typedef enum logic [1:0] {
        CPM_CH_OFF,
        CPM_CH_ON,
        CPM_CH_TRIPPED,
        CPM_CH_ERROR
    } cpm_chan_e;

endpackage : cpm_pkg

// *** cpm_trip_timer.sv ***
// trip delay timer: qualifies an over-level condition for a delay in ms
// assumes over_i is produced on clk_sys_i
`timescale 1ns/100ps
`default_nettype none
`include "cpm_params.svh"

module cpm_trip_timer #(
    parameter int unsigned TICK_CYCLES = `CPM_MS_NS / `CPM_CLK_PERIOD_NS
) (
    input  wire logic           clk_sys_i,
    input  wire logic           rst_n_i,
    input  wire logic           over_i,
    input  wire cpm_pkg::cpm_ms_t delay_ms_i,
    output logic                expired_o
);
    import cpm_pkg::*;

    logic [`CPM_CW-1:0] tick_cnt_reg;
    cpm_ms_t            ms_cnt_reg;
    logic               ms_full;

    assign ms_full = &ms_cnt_reg;

    // ****************************************************************
    // prescaler, restarted with the condition so no partial ms counts
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_cnt_reg <= '0;
        else if (!over_i)
            tick_cnt_reg <= '0;
        else if (tick_cnt_reg == `CPM_CW'(TICK_CYCLES - 1))
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    // ****************************************************************
    // elapsed whole milliseconds, saturating
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ms_cnt_reg <= '0;
        else if (!over_i)
            ms_cnt_reg <= '0;
        else if (tick_cnt_reg == `CPM_CW'(TICK_CYCLES - 1) && !ms_full)
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end

    // never early: only whole counted ms are compared
    assign expired_o = over_i && (ms_cnt_reg >= delay_ms_i);

endmodule : cpm_trip_timer
`default_nettype wire

// *** cpm_channel_monitor.sv ***
// protection supervisor for one programmable power output channel
// assumes measurements arrive on clk_sys_i; comparator pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "cpm_params.svh"

module cpm_channel_monitor #(
    parameter int unsigned TICK_CYCLES = `CPM_MS_NS / `CPM_CLK_PERIOD_NS
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    // voltage settings
    input  wire logic                  vset_we_i,
    input  wire cpm_pkg::cpm_volt_t    vset_i,
    input  wire logic                  vlim_we_i,
    input  wire cpm_pkg::cpm_volt_t    vlim_i,
    input  wire logic                  vg_en_i,
    input  wire cpm_pkg::cpm_vg_type_e vg_type_i,
    input  wire logic                  vtrip_we_i,
    input  wire cpm_pkg::cpm_volt_t    vtrip_i,
    input  wire cpm_pkg::cpm_ms_t      vdelay_i,
    // power settings
    input  wire logic                  pset_we_i,
    input  wire cpm_pkg::cpm_pow_t     pset_i,
    input  wire logic                  plim_we_i,
    input  wire cpm_pkg::cpm_pow_t     plim_i,
    input  wire logic                  pg_en_i,
    input  wire logic                  ptrip_we_i,
    input  wire cpm_pkg::cpm_pow_t     ptrip_i,
    input  wire cpm_pkg::cpm_ms_t      pdelay_i,
    // temperature settings
    input  wire logic                  tg_en_i,
    input  wire logic                  ttrip_we_i,
    input  wire cpm_pkg::cpm_temp_t    ttrip_i,
    input  wire cpm_pkg::cpm_temp_t    tceil_i,
    input  wire cpm_pkg::cpm_ms_t      tdelay_i,
    // measurements and control
    input  wire cpm_pkg::cpm_volt_t    meas_v_i,
    input  wire cpm_pkg::cpm_pow_t     meas_p_i,
    input  wire cpm_pkg::cpm_temp_t    meas_t_i,
    input  wire logic                  hw_cmp_trip_i,
    input  wire logic                  out_req_i,
    input  wire logic                  clear_i,
    // outputs
    output cpm_pkg::cpm_volt_t         vset_o,
    output cpm_pkg::cpm_volt_t         vlim_o,
    output cpm_pkg::cpm_volt_t         vtrip_o,
    output cpm_pkg::cpm_pow_t          pset_o,
    output cpm_pkg::cpm_pow_t          plim_o,
    output cpm_pkg::cpm_pow_t          ptrip_o,
    output cpm_pkg::cpm_temp_t         ttrip_o,
    output logic                       out_en_o,
    output logic                       crowbar_o,
    output logic                       cv_mode_o,
    output logic                       vg_trip_o,
    output logic                       pg_trip_o,
    output logic                       tg_trip_o,
    output logic                       module_error_o,
    output logic                       trip_event_o,
    output logic                       cfg_reject_o,
    output cpm_pkg::cpm_chan_e         chan_state_o
);
    import cpm_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    // about 3% above setpoint, 1/32 keeps it a shift instead of a divider
    function automatic logic [`CPM_VW:0] cpm_hw_level(input cpm_volt_t v);
        cpm_hw_level = {1'b0, v} + (`CPM_VW+1)'(v >> `CPM_HW_SHIFT);
    endfunction : cpm_hw_level

    function automatic logic cpm_v_above(input cpm_volt_t meas,
                                         input cpm_volt_t set);
        cpm_v_above = {1'b0, meas} > cpm_hw_level(set);
    endfunction : cpm_v_above

    // ****************************************************************
    // declarations
    // ****************************************************************
    cpm_volt_t  vlim_reg;
    cpm_volt_t  vset_reg;
    cpm_volt_t  vtrip_reg;
    cpm_pow_t   plim_reg;
    cpm_pow_t   pset_reg;
    cpm_pow_t   ptrip_reg;
    cpm_temp_t  ttrip_reg;
    logic       cfg_reject_reg;
    logic       cfg_reject_next;
    logic       vg_flag_reg;
    logic       pg_flag_reg;
    logic       tg_flag_reg;
    logic       hw_flag_reg;
    logic       err_flag_reg;
    logic       trip_event_reg;
    logic       cmp_s1_reg;
    logic       cmp_s2_reg;
    logic       cmp_s3_reg;
    logic       cmp_stable_reg;
    cpm_chan_e  state_reg;
    cpm_chan_e  state_next;
    logic       vg_is_hw;
    logic       sw_vg_on;
    logic       hw_vg_on;
    logic       v_over;
    logic       p_over;
    logic       t_over;
    logic       vg_expired;
    logic       pg_expired;
    logic       tg_expired;
    logic       hw_set;
    logic       err_set;
    logic       any_set;
    logic       any_flag;
    logic       vlim_ok;
    logic       vtrip_ok;
    logic       plim_ok;
    logic       ptrip_ok;
    logic       ttrip_ok;

    // ****************************************************************
    // guard selection
    // ****************************************************************
    // type is ignored on a variant with no comparator fitted
    assign vg_is_hw = `CPM_HAS_HW_CMP && (vg_type_i == CPM_VG_HW);
    assign sw_vg_on = vg_en_i && !vg_is_hw;
    assign hw_vg_on = vg_en_i && vg_is_hw;

    // ****************************************************************
    // write qualification
    // ****************************************************************
    assign vlim_ok  = vlim_i <= `CPM_V_MAX;
    assign vtrip_ok = (vtrip_i <= `CPM_V_TRIP_MAX)
                   && (vtrip_i >= vset_reg);
    assign plim_ok  = plim_i <= `CPM_P_MAX;
    assign ptrip_ok = ptrip_i <= plim_reg;
    assign ttrip_ok = ttrip_i <= tceil_i;

    always_comb
    begin
        cfg_reject_next = (vlim_we_i && !vlim_ok)
                       || (vtrip_we_i && !vtrip_ok)
                       || (plim_we_i && !plim_ok)
                       || (ptrip_we_i && !ptrip_ok)
                       || (ttrip_we_i && !ttrip_ok);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_reject_reg <= 1'b0;
        else
            cfg_reject_reg <= cfg_reject_next;
    end

    // ****************************************************************
    // voltage ceiling and setpoint
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            vlim_reg <= `CPM_V_MAX;
        else if (vlim_we_i && vlim_ok)
            vlim_reg <= vlim_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            vset_reg <= '0;
        else if (vlim_we_i && vlim_ok)
            vset_reg <= (vset_reg > vlim_i) ? vlim_i : vset_reg;
        else if (vset_we_i)
            vset_reg <= (vset_i > vlim_reg) ? vlim_reg : vset_i;
    end

    // ****************************************************************
    // voltage trip level
    // ****************************************************************
    // a setpoint rise drags the level up; a fall leaves it where it is
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            vtrip_reg <= `CPM_V_TRIP_MAX;
        else if (vtrip_we_i && vtrip_ok)
            vtrip_reg <= vtrip_i;
        else if (vset_reg > vtrip_reg)
            vtrip_reg <= vset_reg;
    end

    // ****************************************************************
    // power ceiling, setpoint and trip level
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            plim_reg <= `CPM_P_MAX;
        else if (plim_we_i && plim_ok)
            plim_reg <= plim_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pset_reg <= '0;
        else if (plim_we_i && plim_ok)
            pset_reg <= (pset_reg > plim_i) ? plim_i : pset_reg;
        else if (pset_we_i)
            pset_reg <= (pset_i > plim_reg) ? plim_reg : pset_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ptrip_reg <= `CPM_P_MAX;
        else if (plim_we_i && plim_ok)
            ptrip_reg <= (ptrip_reg > plim_i) ? plim_i : ptrip_reg;
        else if (ptrip_we_i && ptrip_ok)
            ptrip_reg <= ptrip_i;
    end

    // ****************************************************************
    // temperature trip level, one set per channel instance
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ttrip_reg <= `CPM_T_TRIP_RST;
        else if (ttrip_we_i && ttrip_ok)
            ttrip_reg <= ttrip_i;
        else if (ttrip_reg > tceil_i)
            ttrip_reg <= tceil_i;
    end

    // ****************************************************************
    // comparator pin synchroniser
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
            cmp_s3_reg <= 1'b0;
        end
        else
        begin
            cmp_s1_reg <= hw_cmp_trip_i;
            cmp_s2_reg <= cmp_s1_reg;
            cmp_s3_reg <= cmp_s2_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cmp_stable_reg <= 1'b0;
        else if (cmp_s2_reg == cmp_s3_reg)
            cmp_stable_reg <= cmp_s3_reg;
    end

    // ****************************************************************
    // over-level detection and delay timers
    // ****************************************************************
    assign v_over = sw_vg_on && (meas_v_i >= vtrip_reg);
    assign p_over = pg_en_i && (meas_p_i >= ptrip_reg);
    assign t_over = tg_en_i && (meas_t_i >= ttrip_reg);

    cpm_trip_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_vg_timer (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .over_i      (v_over),
        .delay_ms_i  (vdelay_i),
        .expired_o   (vg_expired)
    );

    cpm_trip_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_pg_timer (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .over_i      (p_over),
        .delay_ms_i  (pdelay_i),
        .expired_o   (pg_expired)
    );

    cpm_trip_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tg_timer (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .over_i      (t_over),
        .delay_ms_i  (tdelay_i),
        .expired_o   (tg_expired)
    );

    // fixed threshold, no timer: fastest possible response
    assign hw_set  = hw_vg_on
                  && (cpm_v_above(meas_v_i, vset_reg) || cmp_stable_reg);
    // last resort when neither voltage guard is switched on
    assign err_set = !vg_en_i && cpm_v_above(meas_v_i, vset_reg);

    // ****************************************************************
    // latched trip flags, a new trip wins over a clear
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vg_flag_reg  <= 1'b0;
            pg_flag_reg  <= 1'b0;
            tg_flag_reg  <= 1'b0;
            hw_flag_reg  <= 1'b0;
            err_flag_reg <= 1'b0;
        end
        else
        begin
            vg_flag_reg  <= vg_expired || (vg_flag_reg && !clear_i);
            pg_flag_reg  <= pg_expired || (pg_flag_reg && !clear_i);
            tg_flag_reg  <= tg_expired || (tg_flag_reg && !clear_i);
            hw_flag_reg  <= hw_set || (hw_flag_reg && !clear_i);
            err_flag_reg <= err_set || (err_flag_reg && !clear_i);
        end
    end

    assign any_set  = vg_expired || pg_expired || tg_expired
                   || hw_set || err_set;
    assign any_flag = vg_flag_reg || pg_flag_reg || tg_flag_reg
                   || hw_flag_reg || err_flag_reg;

    // one pulse per new guard or crowbar trip for the event log; a module error gives none
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            trip_event_reg <= 1'b0;
        else
            trip_event_reg <= (vg_expired && !vg_flag_reg)
                           || (pg_expired && !pg_flag_reg)
                           || (tg_expired && !tg_flag_reg)
                           || (hw_set && !hw_flag_reg);
    end

    // ****************************************************************
    // channel state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CPM_CH_OFF:
                if (out_req_i && !any_flag && !any_set)
                    state_next = CPM_CH_ON;
            CPM_CH_ON:
                if (err_set)
                    state_next = CPM_CH_ERROR;
                else if (any_set)
                    state_next = CPM_CH_TRIPPED;
                else if (!out_req_i)
                    state_next = CPM_CH_OFF;
            CPM_CH_TRIPPED:
                if (!any_flag)
                    state_next = CPM_CH_OFF;
            CPM_CH_ERROR:
                if (!any_flag)
                    state_next = CPM_CH_OFF;
            default:
                state_next = CPM_CH_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_reg <= CPM_CH_OFF;
        else
            state_reg <= state_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // output only requested again after a clear; never re-armed silently
    assign out_en_o       = (state_reg == CPM_CH_ON);
    assign crowbar_o      = hw_flag_reg;
    // guard off: reaching setpoint is plain regulation, not a fault
    assign cv_mode_o      = !vg_en_i && out_en_o
                         && (meas_v_i >= vset_reg);
    assign vg_trip_o      = vg_flag_reg || hw_flag_reg;
    assign pg_trip_o      = pg_flag_reg;
    assign tg_trip_o      = tg_flag_reg;
    assign module_error_o = err_flag_reg;
    assign trip_event_o   = trip_event_reg;
    assign cfg_reject_o   = cfg_reject_reg;
    assign chan_state_o   = state_reg;
    assign vset_o         = vset_reg;
    assign vlim_o         = vlim_reg;
    assign vtrip_o        = vtrip_reg;
    assign pset_o         = pset_reg;
    assign plim_o         = plim_reg;
    assign ptrip_o        = ptrip_reg;
    assign ttrip_o        = ttrip_reg;

endmodule : cpm_channel_monitor
`default_nettype wire

// *** cpm_channel_properties.sv ***
// port checker for one protection channel
// assumes a bind from the bench; one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "cpm_params.svh"
module cpm_channel_properties
    import cpm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic         clk_sys_i, rst_n_i, vg_en_i, clear_i,
    input wire cpm_vg_type_e vg_type_i,
    input wire cpm_ms_t      vdelay_i,
    input wire cpm_volt_t    meas_v_i, vset_o, vlim_o, vtrip_o,
    input wire cpm_pow_t     pset_o, plim_o, ptrip_o,
    input wire cpm_temp_t    tceil_i, ttrip_o,
    input wire logic         out_en_o, cv_mode_o, vg_trip_o, pg_trip_o,
    input wire logic         tg_trip_o, crowbar_o, module_error_o,
    input wire logic         trip_event_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic any_t = vg_trip_o | pg_trip_o | tg_trip_o;
    // 3% band as the design rounds it: vset plus vset/32
    wire cpm_volt_t band = vset_o + (vset_o >> 5);
    vset_cap_a: assert property (vset_o <= vlim_o
        && vlim_o <= `CPM_V_MAX) else $error("setpoint above ceiling");
    vtrip_max_a: assert property (vtrip_o <= `CPM_V_TRIP_MAX)
        else $error("voltage trip level above maximum");
    vtrip_follow_a: assert property (vtrip_o >= $past(vset_o))
        else $error("voltage trip level below setpoint");
    ptrip_cap_a: assert property (ptrip_o <= plim_o
        && pset_o <= plim_o) else $error("power level above ceiling");
    ttrip_cap_a: assert property (ttrip_o <= $past(tceil_i))
        else $error("temperature trip above ceiling");
    cv_report_a: assert property (cv_mode_o == (!vg_en_i && out_en_o
        && meas_v_i >= vset_o)) else $error("cv flag wrong");
    sw_trip_a: assert property (vg_en_i && vg_type_i == CPM_VG_SW
        && vdelay_i == 0 && meas_v_i >= vtrip_o |=> vg_trip_o)
        else $error("voltage guard did not trip");
    hw_trip_a: assert property (vg_en_i && vg_type_i == CPM_VG_HW
        && meas_v_i > band |=> crowbar_o && vg_trip_o)
        else $error("crowbar did not fire");
    fallback_err_a: assert property (!vg_en_i && meas_v_i > band
        |=> module_error_o) else $error("fallback missed overshoot");
    trip_event_a: assert property ($rose(any_t) |-> trip_event_o)
        else $error("trip event missing");
    trip_latch_a: assert property (vg_trip_o && !clear_i |=> vg_trip_o)
        else $error("trip flag dropped");
    trip_off_a: assert property (any_t |=> !out_en_o)
        else $error("output on while tripped");
    clear_only_a: assert property ($fell(vg_trip_o) |-> $past(clear_i))
        else $error("trip flag cleared without clear");
    cover property ($rose(vg_trip_o));
    cover property ($rose(pg_trip_o));
    cover property ($rose(tg_trip_o));
    cover property ($rose(crowbar_o));
    cover property ($rose(module_error_o));
endmodule : cpm_channel_properties
`default_nettype wire

// *** cpm_plant_model.sv ***
// output stage and measurement front end stand-in
// assumes the bench sets the levels it reports
`timescale 1ns/100ps
`default_nettype none
module cpm_plant_model
    import cpm_pkg::*;
(
    input  wire logic      on_i,
    input  wire cpm_volt_t v_cmd_i,
    input  wire cpm_pow_t  p_cmd_i,
    input  wire cpm_temp_t t_cmd_i,
    input  wire logic      pin_cmd_i,
    output cpm_volt_t      meas_v_o,
    output cpm_pow_t       meas_p_o,
    output cpm_temp_t      meas_t_o,
    output logic           hw_cmp_o
);
    // external source may hold voltage up, but no power flows when off
    assign meas_v_o = v_cmd_i;
    assign meas_p_o = on_i ? p_cmd_i : 16'h0000;
    assign meas_t_o = t_cmd_i;
    assign hw_cmp_o = pin_cmd_i;
endmodule : cpm_plant_model
`default_nettype wire

// *** cpm_channel_monitor_test.sv ***
// self-checking bench for one protection channel
// assumes the plant model and checker files compile first
`timescale 1ns/100ps
`default_nettype none
`include "cpm_params.svh"
module cpm_channel_monitor_test;
    import cpm_pkg::*;
    localparam int unsigned TICK_CYCLES = 4;
    logic clk_sys_i, rst_n_i, vset_we_i, vlim_we_i, vg_en_i, vtrip_we_i;
    logic pset_we_i, plim_we_i, pg_en_i, ptrip_we_i, tg_en_i, ttrip_we_i;
    logic out_req_i, clear_i, hw_cmp_trip_i, pin;
    logic out_en_o, crowbar_o, cv_mode_o, vg_trip_o, pg_trip_o, tg_trip_o;
    logic module_error_o, trip_event_o, cfg_reject_o;
    cpm_vg_type_e vg_type_i;
    cpm_chan_e    chan_state_o;
    cpm_volt_t vset_i, vlim_i, vtrip_i, meas_v_i, vset_o, vlim_o, vtrip_o, v;
    cpm_pow_t  pset_i, plim_i, ptrip_i, meas_p_i, pset_o, plim_o, ptrip_o, p;
    cpm_temp_t ttrip_i, tceil_i, meas_t_i, ttrip_o, t;
    cpm_ms_t   vdelay_i, pdelay_i, tdelay_i;
    int n_fail, n_tests, n;
    wire logic [4:0] flg = {module_error_o, crowbar_o, tg_trip_o,
                            pg_trip_o, vg_trip_o};
    cpm_channel_monitor #(.TICK_CYCLES(TICK_CYCLES)) dut_u (.*);
    cpm_plant_model plant_u (.on_i(out_en_o), .v_cmd_i(v), .p_cmd_i(p),
        .t_cmd_i(t), .pin_cmd_i(pin), .meas_v_o(meas_v_i),
        .meas_p_o(meas_p_i), .meas_t_o(meas_t_i), .hw_cmp_o(hw_cmp_trip_i));
    initial
    begin
        clk_sys_i = 0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task tick(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask : tick
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task wr(input int sel, input logic [15:0] d);
        {vlim_i, vset_i, vtrip_i, plim_i, pset_i} = {5{d}};
        {vlim_we_i, vset_we_i, vtrip_we_i, plim_we_i, pset_we_i} =
            5'h10 >> sel;
        tick(1);
        {vlim_we_i, vset_we_i, vtrip_we_i, plim_we_i, pset_we_i} = 5'h00;
        tick(2);
    endtask : wr
    // cycles from raising a condition until flag k is seen
    task trip_time(input int k);
        n = 0;
        while (flg[k] !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
    endtask : trip_time
    task clr;
        clear_i = 1;
        tick(1);
        clear_i = 0;
        tick(3);
    endtask : clr
    task t_cfg;
        check(vlim_o, `CPM_V_MAX);
        check(ptrip_o, `CPM_P_MAX);
        check(ttrip_o, `CPM_T_TRIP_RST);
        wr(0, 16'h7530);
        wr(1, 16'h88b8);
        check(vset_o, 16'h7530);
        vtrip_i = 16'h9e35;
        vtrip_we_i = 1;
        tick(1);
        vtrip_we_i = 0;
        check(cfg_reject_o, 16'h0001);
        check(vtrip_o, 16'h9e34);
        tick(1);
        wr(2, 16'h7530);
        wr(0, 16'h9c40);
        wr(1, 16'h88b8);
        check(vtrip_o, 16'h88b8);
        wr(1, 16'h2710);
        check(vtrip_o, 16'h88b8);
        wr(3, 16'h2710);
        wr(4, 16'h2ee0);
        check(ptrip_o, 16'h2710);
        check(pset_o, 16'h2710);
        check(plim_o, 16'h2710);
        $display("test cfg done");
    endtask : t_cfg
    task t_volt;
        vdelay_i = 2;
        vg_en_i = 1;
        v = 16'h88b8;
        tick(5);
        v = 0;
        tick(1);
        v = 16'h88b8;
        trip_time(0);
        check(n[15:0], 16'h0009);
        check(trip_event_o, 1'b1);
        check(out_en_o, 1'b0);
        v = 0;
        tick(3);
        check(vg_trip_o, 1'b1);
        clr();
        check(vg_trip_o, 1'b0);
        check(out_en_o, 1'b1);
        vdelay_i = 0;
        v = 16'h88b8;
        trip_time(0);
        check(n[15:0], 16'h0001);
        v = 0;
        clr();
        $display("test volt done");
    endtask : t_volt
    task t_pt;
        vg_en_i = 0;
        v = 16'h2710;
        tick(1);
        check(cv_mode_o, 1'b1);
        check(module_error_o, 1'b0);
        v = 0;
        pdelay_i = 1;
        pg_en_i = 1;
        p = 16'h2710;
        trip_time(1);
        check(n[15:0], 16'h0005);
        p = 0;
        clr();
        tg_en_i = 1;
        tdelay_i = 1;
        t = 8'h3b;
        tick(10);
        check(tg_trip_o, 1'b0);
        t = 8'h3c;
        trip_time(2);
        check(n[15:0], 16'h0005);
        t = 0;
        clr();
        $display("test power temp done");
    endtask : t_pt
    task t_hw;
        vg_en_i = 1;
        vg_type_i = CPM_VG_HW;
        v = 16'h2848;
        tick(5);
        check(crowbar_o, 1'b0);
        v = 16'h2849;
        trip_time(3);
        check(n[15:0], 16'h0001);
        v = 0;
        clr();
        pin = 1;
        trip_time(3);
        check(n < 8, 1'b1);
        pin = 0;
        tick(5);
        clr();
        vg_en_i = 0;
        v = 16'h2849;
        trip_time(4);
        check(n[15:0], 16'h0001);
        check(chan_state_o, CPM_CH_ERROR);
        v = 0;
        clr();
        $display("test hw fallback done");
    endtask : t_hw
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        {vset_we_i, vlim_we_i, vg_en_i, vtrip_we_i, pset_we_i} = 0;
        {plim_we_i, pg_en_i, ptrip_we_i, tg_en_i, ttrip_we_i, pin} = 0;
        {clear_i, vset_i, vlim_i, vtrip_i, pset_i, plim_i, ptrip_i} = 0;
        {vdelay_i, pdelay_i, tdelay_i, ttrip_i, v, p, t} = 0;
        vg_type_i = CPM_VG_SW;
        tceil_i = 8'h64;
        out_req_i = 1;
        n_fail = 0;
        n_tests = 0;
        rst_n_i = 0;
        tick(2);
        rst_n_i = 1;
        tick(3);
        t_cfg();
        t_volt();
        t_pt();
        t_hw();
        finish_test();
    end
    initial
    begin
        #2000000;
        n_fail++;
        finish_test();
    end
endmodule : cpm_channel_monitor_test
bind cpm_channel_monitor cpm_channel_properties
    #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
`default_nettype wire
